//--- hdl/cpr_pkg.sv
// cpr_pkg: register map, reset values and shared types of the port
// register bank.
// assumes an eight-bit register pointer and byte-wide data from the host
// interface logic that sits in front of the bank.
package cpr_pkg;

	// ------------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_CURRENT_MEASUREMENT = 8'h00;
	localparam logic [7:0] ADDR_CHARGE_TOTAL_BYTE3 = 8'h01;
	localparam logic [7:0] ADDR_CHARGE_TOTAL_BYTE2 = 8'h02;
	localparam logic [7:0] ADDR_CHARGE_TOTAL_BYTE1 = 8'h03;
	localparam logic [7:0] ADDR_CHARGE_TOTAL_BYTE0 = 8'h04;
	localparam logic [7:0] ADDR_MISC_STATUS = 8'h0f;
	localparam logic [7:0] ADDR_IRQ_CAUSE = 8'h10;
	localparam logic [7:0] ADDR_GENERAL_STATE = 8'h11;
	localparam logic [7:0] ADDR_ACCEPTED_PROFILE_A = 8'h12;
	localparam logic [7:0] ADDR_ACCEPTED_PROFILE_B = 8'h13;
	localparam logic [7:0] ADDR_CONTROL_PIN_LEVELS = 8'h14;
	localparam logic [7:0] ADDR_BASIC_CONTROL = 8'h15;
	localparam logic [7:0] ADDR_EMULATION_CONTROL = 8'h16;
	localparam logic [7:0] ADDR_SWITCH_CONTROL = 8'h17;
	localparam logic [7:0] ADDR_ATTACH_SENSE_CONTROL = 8'h18;
	localparam logic [7:0] ADDR_MAX_CURRENT_SELECT = 8'h19;
	localparam logic [7:0] ADDR_RATION_THRESHOLD_HI = 8'h1a;
	localparam logic [7:0] ADDR_RATION_THRESHOLD_LO = 8'h1b;
	localparam logic [7:0] ADDR_FAULT_RETRY_CONTROL = 8'h1c;
	localparam logic [7:0] ADDR_SUCCESS_CURRENT_LEVEL = 8'h1e;
	localparam logic [7:0] ADDR_CHARGE_SENSE_TIME = 8'h1f;
	localparam logic [7:0] ADDR_SPEC_PROFILE_ENABLES = 8'h20;
	localparam logic [7:0] ADDR_LEGACY_PROFILE_ENABLES = 8'h21;
	localparam logic [7:0] ADDR_SPEC_PROFILE_TIMEOUT = 8'h22;

	// writable block runs from 15h with a hole at 1dh; its slot index is addr - 15h
	localparam logic [7:0] ADDR_RW_FIRST = 8'h15;
	localparam int RW_COUNT = 14;
	localparam logic [3:0] RW_SLOT_HOLE = 4'h8;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_BASIC_CONTROL = 8'h01;
	localparam logic [7:0] RST_EMULATION_CONTROL = 8'h8c;
	localparam logic [7:0] RST_SWITCH_CONTROL = 8'h04;
	localparam logic [7:0] RST_ATTACH_SENSE_CONTROL = 8'h46;
	localparam logic [7:0] RST_MAX_CURRENT_SELECT = 8'h00;
	localparam logic [7:0] RST_RATION_THRESHOLD = 8'hff;
	localparam logic [7:0] RST_FAULT_RETRY_CONTROL = 8'h2a;
	localparam logic [7:0] RST_SUCCESS_CURRENT_LEVEL = 8'h04;
	localparam logic [7:0] RST_CHARGE_SENSE_TIME = 8'h03;
	localparam logic [7:0] RST_SPEC_PROFILE_ENABLES = 8'h06;
	localparam logic [7:0] RST_LEGACY_PROFILE_ENABLES = 8'h00;
	localparam logic [7:0] RST_SPEC_PROFILE_TIMEOUT = 8'h10;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	// emulation_control: custom profile join and placement
	localparam int EMU_CUSTOM_EN_BIT = 0;
	localparam int EMU_CUSTOM_LAST_BIT = 1;
	// misc_status: pin levels beside the emulation state
	localparam int MISC_ALERT_BIT = 7;
	localparam int MISC_ATTACH_BIT = 6;
	// number of custom stimulus/response pairs
	localparam logic [1:0] CUSTOM_PAIRS = 2'h3;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		CPR_SEQ_IDLE = 2'b00,
		CPR_SEQ_PRESET = 2'b01,
		CPR_SEQ_CUSTOM = 2'b10,
		CPR_SEQ_DONE = 2'b11
	} cpr_seq_state_t;

	// rw slot index of a writable address, or 4'hf when none
	function automatic logic [3:0] cpr_rw_slot(input logic [7:0] addr);
		logic [7:0] diff;
		diff = addr - ADDR_RW_FIRST;
		if (addr >= ADDR_RW_FIRST && diff < 8'(RW_COUNT) &&
			diff[3:0] != RW_SLOT_HOLE)
			return diff[3:0];
		return 4'hf;
	endfunction

endpackage

//--- hdl/cpr_cfg_mem.sv
// cpr_cfg_mem: the thirteen writable configuration bytes, held in fourteen slots.
// assumes a slot index from the bank's decoder; read data is registered.
// contents are retained across sleep, so only reset reloads defaults.
module cpr_cfg_mem
	import cpr_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic wr_en_in,
	input wire logic [3:0] wr_slot_in,
	input wire logic [7:0] wr_data_in,
	input wire logic [3:0] rd_slot_in,
	output logic [7:0] rd_data_out,
	output logic [8*RW_COUNT-1:0] all_out
);

	logic [7:0] mem_ff [RW_COUNT];
	logic [7:0] rd_ff;
	logic [7:0] rst_val [RW_COUNT];

	// ------------------------------------------------------------------
	// defaults, slot order 15h..22h with 1dh a hole
	// ------------------------------------------------------------------
	assign rst_val[0] = RST_BASIC_CONTROL;
	assign rst_val[1] = RST_EMULATION_CONTROL;
	assign rst_val[2] = RST_SWITCH_CONTROL;
	assign rst_val[3] = RST_ATTACH_SENSE_CONTROL;
	assign rst_val[4] = RST_MAX_CURRENT_SELECT;
	assign rst_val[5] = RST_RATION_THRESHOLD;
	assign rst_val[6] = RST_RATION_THRESHOLD;
	assign rst_val[7] = RST_FAULT_RETRY_CONTROL;
	assign rst_val[8] = RST_ZERO;
	assign rst_val[9] = RST_SUCCESS_CURRENT_LEVEL;
	assign rst_val[10] = RST_CHARGE_SENSE_TIME;
	assign rst_val[11] = RST_SPEC_PROFILE_ENABLES;
	assign rst_val[12] = RST_LEGACY_PROFILE_ENABLES;
	assign rst_val[13] = RST_SPEC_PROFILE_TIMEOUT;

	// slot 8 is the unmapped 1dh address; the decoder never selects it
	always_ff @(posedge clk_in) begin
		for (int i = 0; i < RW_COUNT; i++) begin
			if (reset_in)
				mem_ff[i] <= rst_val[i];
			else if (wr_en_in && wr_slot_in == 4'(i))
				mem_ff[i] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in)
			rd_ff <= RST_ZERO;
		else if (rd_slot_in < 4'(RW_COUNT))
			rd_ff <= mem_ff[rd_slot_in];
		else
			rd_ff <= RST_ZERO;
	end

	assign rd_data_out = rd_ff;

	for (genvar g = 0; g < RW_COUNT; g++) begin : g_flat
		assign all_out[8*g +: 8] = mem_ff[g];
	end

endmodule // cpr_cfg_mem

//--- hdl/cpr_seq.sv
// cpr_seq: orders the custom profile within the dedicated emulation cycle
// and steps through its three stimulus/response pairs.
// assumes the analog side reports one pulse per finished preset profile
// round and one per finished custom pair.
module cpr_seq
	import cpr_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	input wire logic start_in,
	input wire logic custom_en_in,
	input wire logic custom_last_in,
	input wire logic preset_done_in,
	input wire logic pair_done_in,
	output logic custom_active_out,
	output logic [1:0] pair_idx_out,
	output logic cycle_done_out
);

	cpr_seq_state_t state_ff, nxt_state;
	logic [1:0] pair_ff, nxt_pair;
	logic custom_seen_ff, nxt_custom_seen;
	logic last_pair;

	assign last_pair = (pair_ff == CUSTOM_PAIRS - 2'h1);

	always_comb begin
		nxt_state = state_ff;
		nxt_pair = pair_ff;
		nxt_custom_seen = custom_seen_ff;
		unique case (state_ff)
			CPR_SEQ_IDLE: begin
				if (start_in) begin
					nxt_custom_seen = 1'b0;
					nxt_pair = 2'h0;
					// custom first unless placed last
					if (custom_en_in && !custom_last_in)
						nxt_state = CPR_SEQ_CUSTOM;
					else
						nxt_state = CPR_SEQ_PRESET;
				end
			end
			CPR_SEQ_PRESET: begin
				if (preset_done_in) begin
					if (custom_en_in && !custom_seen_ff) begin
						nxt_state = CPR_SEQ_CUSTOM;
						nxt_pair = 2'h0;
					end else
						nxt_state = CPR_SEQ_DONE;
				end
			end
			CPR_SEQ_CUSTOM: begin
				// pairs are applied strictly one after another
				if (pair_done_in) begin
					if (last_pair) begin
						nxt_custom_seen = 1'b1;
						nxt_pair = 2'h0;
						nxt_state = custom_last_in ? CPR_SEQ_DONE :
							CPR_SEQ_PRESET;
					end else
						nxt_pair = pair_ff + 2'h1;
				end
			end
			CPR_SEQ_DONE: nxt_state = CPR_SEQ_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			state_ff <= CPR_SEQ_IDLE;
			pair_ff <= 2'h0;
			custom_seen_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			pair_ff <= nxt_pair;
			custom_seen_ff <= nxt_custom_seen;
		end
	end

	assign custom_active_out = (state_ff == CPR_SEQ_CUSTOM);
	assign pair_idx_out = pair_ff;
	assign cycle_done_out = (state_ff == CPR_SEQ_DONE);

endmodule // cpr_seq

//--- hdl/cpr_bank.sv
// cpr_bank: host-visible register bank of the port power controller.
// assumes a serial host front end that delivers a decoded register pointer
// with one-cycle read and write strobes; the read byte is valid on the
// cycle after the read strobe.
//
// Summary of operation
// - custom profile may be included in the dedicated emulation cycle
// - custom profile placed first or last in the cycle order
// - custom profile runs three stimulus/response pairs in fixed order
// - registers are reached over a two-wire SMBus or I2C host port
// - retained configuration and rationing data survive the sleep state
// - registers not retained lose their contents on entering sleep
// - 00h is read-only latest port current, default 00h
// - 01h..04h read-only total charge, msb first, default zero
// - 0Fh read-only emulation status plus alert and attach pin levels
// - 10h records the alert causes, default 00h
// - 12h and 13h read-only accepted emulation profile
// - 14h read-only mirror of internal control pin levels
// - 17h read/write switch functions, default 04h
// - 18h read/write attach detection configuration, default 46h
// - 19h read/write maximum current limit select, default 00h
// - 1Ah/1Bh read/write rationing current threshold, default FFh each
// - 1Ch read/write fault auto-recovery configuration, default 2Ah
// - 1Eh read/write emulation success current level, default 04h
// - 1Fh read/write charge detection time, default 03h
// - 20h spec profile enables default 06h, 21h legacy enables 00h
// - 22h read/write spec profile timeout, default 10h
// - power-on reset loads every register with its default
// - undefined addresses read 00h and ignore writes
module cpr_bank
	import cpr_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_in,
	// host side, from the serial front end
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	// measurements and status from the port
	input wire logic [7:0] current_meas_in,
	input wire logic [31:0] charge_total_in,
	input wire logic sleep_in,
	input wire logic [5:0] emu_status_in,
	input wire logic alert_level_in,
	input wire logic attach_sense_in_n,
	input wire logic [7:0] irq_event_in,
	input wire logic [7:0] general_state_in,
	input wire logic [15:0] accepted_profile_in,
	input wire logic [7:0] control_pins_in,
	// emulation cycle steering
	input wire logic emu_start_in,
	input wire logic preset_done_in,
	input wire logic pair_done_in,
	output logic custom_active_out,
	output logic [1:0] pair_idx_out,
	output logic cycle_done_out,
	// configuration out to the switch and emulation logic
	output logic [7:0] switch_control_out,
	output logic [7:0] attach_sense_control_out,
	output logic [7:0] max_current_select_out,
	output logic [15:0] ration_current_limit_out,
	output logic [7:0] fault_retry_control_out,
	output logic [7:0] success_current_level_out,
	output logic [7:0] charge_sense_time_out,
	output logic [7:0] spec_profile_enables_out,
	output logic [7:0] legacy_profile_enables_out,
	output logic [7:0] spec_profile_timeout_out
);

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	logic [3:0] wr_slot;
	logic [3:0] rd_slot;
	logic wr_hit;
	logic [7:0] cfg_rdata;
	logic [8*RW_COUNT-1:0] cfg_all;
	logic rd_is_cfg_ff;
	logic [7:0] status_rdata_ff, nxt_status_rdata;
	logic [7:0] irq_cause_ff;
	logic [7:0] general_state_ff;
	logic [7:0] meas_ff;
	logic [31:0] charge_ff;
	logic [7:0] misc_ff;
	logic [15:0] profile_ff;
	logic [7:0] pins_ff;
	logic irq_clear;
	logic gen_clear;
	logic custom_active;
	logic [1:0] pair_idx;
	logic cycle_done;
	logic custom_active_ff;
	logic [1:0] pair_idx_ff;
	logic cycle_done_ff;

	assign wr_slot = cpr_rw_slot(reg_addr_in);
	assign rd_slot = cpr_rw_slot(reg_addr_in);
	assign wr_hit = reg_wr_in && wr_slot != 4'hf;

	// ------------------------------------------------------------------
	// writable configuration (retained in sleep)
	// ------------------------------------------------------------------
	// retention: sleep_in never touches these bytes
	cpr_cfg_mem u_cfg (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.wr_en_in(wr_hit),
		.wr_slot_in(wr_slot),
		.wr_data_in(reg_wdata_in),
		.rd_slot_in(rd_slot),
		.rd_data_out(cfg_rdata),
		.all_out(cfg_all)
	);

	// ------------------------------------------------------------------
	// read-only status snapshots; lost on entering sleep
	// ------------------------------------------------------------------
	// clear-on-read for the cause bytes; a new event in the same cycle wins
	assign irq_clear = reg_rd_in && reg_addr_in == ADDR_IRQ_CAUSE;
	assign gen_clear = reg_rd_in && reg_addr_in == ADDR_GENERAL_STATE;

	always_ff @(posedge clk_in) begin
		if (reset_in || sleep_in) begin
			meas_ff <= RST_ZERO;
			charge_ff <= {4{RST_ZERO}};
			misc_ff <= RST_ZERO;
			profile_ff <= {2{RST_ZERO}};
			pins_ff <= RST_ZERO;
		end else begin
			meas_ff <= current_meas_in;
			charge_ff <= charge_total_in;
			misc_ff <= {alert_level_in, attach_sense_in_n,
				emu_status_in};
			profile_ff <= accepted_profile_in;
			pins_ff <= control_pins_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in || sleep_in) begin
			irq_cause_ff <= RST_ZERO;
			general_state_ff <= RST_ZERO;
		end else begin
			irq_cause_ff <= (irq_clear ? RST_ZERO : irq_cause_ff) |
				irq_event_in;
			general_state_ff <= (gen_clear ? RST_ZERO : general_state_ff) |
				general_state_in;
		end
	end

	// ------------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------------
	always_comb begin
		nxt_status_rdata = RST_ZERO;
		unique case (reg_addr_in)
			ADDR_CURRENT_MEASUREMENT: nxt_status_rdata = meas_ff;
			ADDR_CHARGE_TOTAL_BYTE3: nxt_status_rdata = charge_ff[31:24];
			ADDR_CHARGE_TOTAL_BYTE2: nxt_status_rdata = charge_ff[23:16];
			ADDR_CHARGE_TOTAL_BYTE1: nxt_status_rdata = charge_ff[15:8];
			ADDR_CHARGE_TOTAL_BYTE0: nxt_status_rdata = charge_ff[7:0];
			ADDR_MISC_STATUS: nxt_status_rdata = misc_ff;
			ADDR_IRQ_CAUSE: nxt_status_rdata = irq_cause_ff;
			ADDR_GENERAL_STATE: nxt_status_rdata = general_state_ff;
			ADDR_ACCEPTED_PROFILE_A: nxt_status_rdata = profile_ff[15:8];
			ADDR_ACCEPTED_PROFILE_B: nxt_status_rdata = profile_ff[7:0];
			ADDR_CONTROL_PIN_LEVELS: nxt_status_rdata = pins_ff;
			default: nxt_status_rdata = RST_ZERO;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			status_rdata_ff <= RST_ZERO;
			rd_is_cfg_ff <= 1'b0;
		end else if (reg_rd_in) begin
			status_rdata_ff <= nxt_status_rdata;
			rd_is_cfg_ff <= (rd_slot != 4'hf);
		end
	end

	// both sources are flip-flops; the select is a flip-flop too
	assign reg_rdata_out = rd_is_cfg_ff ? cfg_rdata : status_rdata_ff;

	// ------------------------------------------------------------------
	// emulation cycle sequencing
	// ------------------------------------------------------------------
	cpr_seq u_seq (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.start_in(emu_start_in),
		.custom_en_in(cfg_all[8*1 + EMU_CUSTOM_EN_BIT]),
		.custom_last_in(cfg_all[8*1 + EMU_CUSTOM_LAST_BIT]),
		.preset_done_in(preset_done_in),
		.pair_done_in(pair_done_in),
		.custom_active_out(custom_active),
		.pair_idx_out(pair_idx),
		.cycle_done_out(cycle_done)
	);

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			custom_active_ff <= 1'b0;
			pair_idx_ff <= 2'h0;
			cycle_done_ff <= 1'b0;
		end else begin
			custom_active_ff <= custom_active;
			pair_idx_ff <= pair_idx;
			cycle_done_ff <= cycle_done;
		end
	end

	assign custom_active_out = custom_active_ff;
	assign pair_idx_out = pair_idx_ff;
	assign cycle_done_out = cycle_done_ff;

	// ------------------------------------------------------------------
	// configuration outputs, straight from the storage flops
	// ------------------------------------------------------------------
	assign switch_control_out = cfg_all[8*2 +: 8];
	assign attach_sense_control_out = cfg_all[8*3 +: 8];
	assign max_current_select_out = cfg_all[8*4 +: 8];
	assign ration_current_limit_out = {cfg_all[8*5 +: 8],
		cfg_all[8*6 +: 8]};
	assign fault_retry_control_out = cfg_all[8*7 +: 8];
	assign success_current_level_out = cfg_all[8*9 +: 8];
	assign charge_sense_time_out = cfg_all[8*10 +: 8];
	assign spec_profile_enables_out = cfg_all[8*11 +: 8];
	assign legacy_profile_enables_out = cfg_all[8*12 +: 8];
	assign spec_profile_timeout_out = cfg_all[8*13 +: 8];

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	sequence s_rw_write;
		reg_wr_in && reg_addr_in == ADDR_SWITCH_CONTROL;
	endsequence
	sequence s_read_back;
		reg_rd_in && reg_addr_in == ADDR_SWITCH_CONTROL;
	endsequence

	property p_reset_defaults;
		@(posedge clk_in) reset_in |=>
			switch_control_out == RST_SWITCH_CONTROL &&
			attach_sense_control_out == RST_ATTACH_SENSE_CONTROL &&
			ration_current_limit_out == 16'hffff &&
			spec_profile_timeout_out == RST_SPEC_PROFILE_TIMEOUT;
	endproperty
	a_reset_defaults: assert property (p_reset_defaults)
		else $error("defaults not loaded by reset");

	property p_write_takes;
		@(posedge clk_in) disable iff (reset_in)
		s_rw_write |=> switch_control_out == $past(reg_wdata_in);
	endproperty
	a_write_takes: assert property (p_write_takes)
		else $error("switch control write lost");

	property p_write_read;
		@(posedge clk_in) disable iff (reset_in)
		s_rw_write ##1 (s_read_back and !reg_wr_in) |=>
			reg_rdata_out == switch_control_out;
	endproperty
	a_write_read: assert property (p_write_read)
		else $error("readback differs from stored value");

	property p_unmapped_zero;
		@(posedge clk_in) disable iff (reset_in)
		reg_rd_in && reg_addr_in == 8'h1d |=> reg_rdata_out == RST_ZERO;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero)
		else $error("undefined address read not zero");

	property p_sleep_retains;
		@(posedge clk_in) disable iff (reset_in)
		sleep_in && !reg_wr_in |=> $stable(fault_retry_control_out);
	endproperty
	a_sleep_retains: assert property (p_sleep_retains)
		else $error("retained byte changed in sleep");

	property p_sleep_clears;
		@(posedge clk_in) disable iff (reset_in)
		sleep_in |=> meas_ff == RST_ZERO && irq_cause_ff == RST_ZERO;
	endproperty
	a_sleep_clears: assert property (p_sleep_clears)
		else $error("volatile status kept over sleep");

	property p_event_wins;
		@(posedge clk_in) disable iff (reset_in || sleep_in)
		irq_event_in[0] |=> irq_cause_ff[0];
	endproperty
	a_event_wins: assert property (p_event_wins)
		else $error("alert cause lost");

	property p_pin_mirror;
		@(posedge clk_in) disable iff (reset_in || sleep_in)
		1'b1 |=> misc_ff[MISC_ALERT_BIT] == $past(alert_level_in) &&
			misc_ff[MISC_ATTACH_BIT] == $past(attach_sense_in_n);
	endproperty
	a_pin_mirror: assert property (p_pin_mirror)
		else $error("pin levels not mirrored");

	property p_custom_first;
		@(posedge clk_in) disable iff (reset_in)
		emu_start_in && !custom_active && !cycle_done &&
		cfg_all[8 + EMU_CUSTOM_EN_BIT] && !cfg_all[8 + EMU_CUSTOM_LAST_BIT]
		&& u_seq.state_ff == CPR_SEQ_IDLE |=> ##1 custom_active_out;
	endproperty
	a_custom_first: assert property (p_custom_first)
		else $error("custom profile not placed first");

	property p_three_pairs;
		@(posedge clk_in) disable iff (reset_in)
		custom_active && pair_done_in && pair_idx == 2'h2 |=>
			!custom_active && pair_idx == 2'h0;
	endproperty
	a_three_pairs: assert property (p_three_pairs)
		else $error("custom profile did not end after third pair");

	property p_clear_on_read;
		@(posedge clk_in) disable iff (reset_in || sleep_in)
		irq_clear && irq_event_in == RST_ZERO |=> irq_cause_ff == RST_ZERO;
	endproperty
	a_clear_on_read: assert property (p_clear_on_read)
		else $error("alert causes not cleared by read");

	sequence s_last_pair_done;
		custom_active && pair_done_in && pair_idx == 2'h2;
	endsequence

	property p_custom_last;
		@(posedge clk_in) disable iff (reset_in)
		s_last_pair_done ##0 cfg_all[8 + EMU_CUSTOM_LAST_BIT] |=>
			##1 cycle_done_out;
	endproperty
	a_custom_last: assert property (p_custom_last)
		else $error("custom profile not placed last");

	property p_rdata_reset;
		@(posedge clk_in) reset_in |=> reg_rdata_out == RST_ZERO;
	endproperty
	a_rdata_reset: assert property (p_rdata_reset)
		else $error("read data not cleared by reset");

	property p_done_pulse;
		@(posedge clk_in) disable iff (reset_in)
		cycle_done_out |=> !cycle_done_out;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("cycle end not a single pulse");

endmodule // cpr_bank

//--- bench/cpr_host.sv
// cpr_host: behavioural register host in place of the serial front end.
// assumes the bank takes strobes on the rising edge; drives on falling.
module cpr_host (
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	output logic [7:0] addr_out,
	output logic wr_out,
	output logic [7:0] wdata_out,
	output logic rd_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
	end
	// released lines show the inverse so a stale value never looks valid
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		wdata_out = d;
		wr_out = 1'b1;
		@(negedge clk_in);
		wr_out = 1'b0;
		addr_out = ~a;
		wdata_out = ~d;
	endtask
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_in);
		addr_out = a;
		rd_out = 1'b1;
		@(negedge clk_in);
		rd_out = 1'b0;
		addr_out = ~a;
		d = rdata_in;
	endtask
endmodule // cpr_host

//--- bench/charger_port_register_bank_test.sv
// charger_port_register_bank_test: self-checking bench of cpr_bank.
// assumes cpr_host drives the register strobes; inputs change at negedge.
module charger_port_register_bank_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in, reset_in, reg_wr_in, reg_rd_in, sleep_in, alert_level_in;
	logic attach_sense_in_n, emu_start_in, preset_done_in, pair_done_in;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, current_meas_in;
	logic [7:0] irq_event_in, general_state_in, control_pins_in;
	logic [7:0] switch_control_out, spec_profile_timeout_out, rd, a, w, d;
	logic [31:0] charge_total_in;
	logic [5:0] emu_status_in;
	logic [15:0] accepted_profile_in, ration_current_limit_out;
	logic custom_active_out, cycle_done_out;
	logic [1:0] pair_idx_out;
	logic [55:0] cfg_o;
	int failures, tests_run;
	// address, write data, default; writes to read-only places must not land
	logic [23:0] rows [24] = '{24'h00_5a00, 24'h01_a500, 24'h04_3300,
		24'h0f_ff00, 24'h10_ff00, 24'h12_1100, 24'h13_2200, 24'h14_4400,
		24'h1d_7700, 24'h23_8800, 24'hff_9900, 24'h15_a501, 24'h16_008c,
		24'h17_5a04, 24'h18_3c46, 24'h19_0700, 24'h1a_12ff, 24'h1b_34ff,
		24'h1c_552a, 24'h1e_0904, 24'h1f_0c03, 24'h20_f906, 24'h21_8100,
		24'h22_ee10};
	logic [15:0] ro_rows [9] = '{16'h005a, 16'h0112, 16'h0234, 16'h0356,
		16'h0478, 16'h0fea, 16'h12c3, 16'h133c, 16'h1496};

	cpr_host u_host (.clk_in, .rdata_in(reg_rdata_out),
		.addr_out(reg_addr_in), .wr_out(reg_wr_in),
		.wdata_out(reg_wdata_in), .rd_out(reg_rd_in));
	cpr_bank u_dut (.clk_in, .reset_in, .reg_addr_in, .reg_wr_in,
		.reg_wdata_in, .reg_rd_in, .reg_rdata_out, .current_meas_in,
		.charge_total_in, .sleep_in, .emu_status_in, .alert_level_in,
		.attach_sense_in_n, .irq_event_in, .general_state_in,
		.accepted_profile_in, .control_pins_in, .emu_start_in,
		.preset_done_in, .pair_done_in, .custom_active_out, .pair_idx_out,
		.cycle_done_out, .switch_control_out,
		.attach_sense_control_out(cfg_o[55:48]),
		.max_current_select_out(cfg_o[47:40]), .ration_current_limit_out,
		.fault_retry_control_out(cfg_o[39:32]),
		.success_current_level_out(cfg_o[31:24]),
		.charge_sense_time_out(cfg_o[23:16]),
		.spec_profile_enables_out(cfg_o[15:8]),
		.legacy_profile_enables_out(cfg_o[7:0]), .spec_profile_timeout_out);

	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	task automatic complete_run();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic rchk(input logic [7:0] ra, input logic [7:0] e);
		u_host.read_reg(ra, rd);
		chk($sformatf("reg %h", ra), {8'h00, e}, {8'h00, rd});
	endtask
	// configuration outputs 18h, 19h, 1ch, 1eh, 1fh, 20h, 21h, msb first
	task automatic cfgchk(input logic [55:0] e);
		for (int i = 0; i < 7; i++)
			chk("config out", {8'h00, e[8*i +: 8]},
				{8'h00, cfg_o[8*i +: 8]});
	endtask
	task automatic pulse(input logic [2:0] v);
		{emu_start_in, preset_done_in, pair_done_in} = v;
		@(negedge clk_in);
		{emu_start_in, preset_done_in, pair_done_in} = 3'h0;
	endtask
	task automatic pairs();
		for (int k = 0; k < 3; k++) begin
			if (k > 0) @(negedge clk_in);
			chk("custom active", 16'h0001, {15'h0000, custom_active_out});
			chk("pair index", 16'(k), {14'h0000, pair_idx_out});
			pulse(3'h1);
		end
	endtask
	// bit0 joins the custom profile, bit1 moves it behind the presets
	task automatic emu(input logic [7:0] cfg);
		u_host.write_reg(8'h16, cfg);
		pulse(3'h4);
		repeat (2) @(negedge clk_in);
		if (cfg[0] && !cfg[1]) begin
			pairs();
			repeat (2) @(negedge clk_in);
		end
		chk("custom idle", 16'h0000, {15'h0000, custom_active_out});
		pulse(3'h2);
		if (cfg[0] && cfg[1]) begin
			repeat (2) @(negedge clk_in);
			pairs();
		end
		for (int i = 0; i < 8 && cycle_done_out !== 1'b1; i++)
			@(negedge clk_in);
		chk("cycle done", 16'h0001, {15'h0000, cycle_done_out});
		if (cycle_done_out !== 1'b1)
			complete_run();
		else
			$display("test emulation %h done", cfg);
	endtask

	// ------------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------------
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	initial begin
		failures = 0;
		tests_run = 0;
		{reset_in, sleep_in, alert_level_in, attach_sense_in_n} = 4'h8;
		{emu_start_in, preset_done_in, pair_done_in} = 3'h0;
		{current_meas_in, irq_event_in, general_state_in} = 24'h00_0000;
		{control_pins_in, emu_status_in, charge_total_in} = 46'h0;
		accepted_profile_in = 16'h0000;
		repeat (20) @(negedge clk_in);
		reset_in = 1'b0;
		foreach (rows[i]) begin
			{a, w, d} = rows[i];
			rchk(a, d);
			u_host.write_reg(a, w);
			if (a >= 8'h15 && a <= 8'h22 && a != 8'h1d) d = w;
			rchk(a, d);
		end
		chk("threshold", 16'h1234, ration_current_limit_out);
		chk("switch", 16'h005a, {8'h00, switch_control_out});
		cfgchk(56'h3c07_5509_0cf9_81);
		chk("timeout", 16'h00ee, {8'h00, spec_profile_timeout_out});
		$display("test register table done");
		current_meas_in = 8'h5a;
		charge_total_in = 32'h1234_5678;
		{alert_level_in, attach_sense_in_n, emu_status_in} = 8'hea;
		accepted_profile_in = 16'hc33c;
		control_pins_in = 8'h96;
		foreach (ro_rows[i])
			rchk(ro_rows[i][15:8], ro_rows[i][7:0]);
		irq_event_in = 8'h05;
		general_state_in = 8'h30;
		@(negedge clk_in);
		{irq_event_in, general_state_in} = 16'h0000;
		rchk(8'h10, 8'h05);
		rchk(8'h11, 8'h30);
		rchk(8'h10, 8'h00);
		irq_event_in = 8'h81;
		@(negedge clk_in);
		irq_event_in = 8'h00;
		sleep_in = 1'b1;
		repeat (2) @(negedge clk_in);
		sleep_in = 1'b0;
		rchk(8'h10, 8'h00);
		rchk(8'h17, 8'h5a);
		$display("test status and sleep done");
		emu(8'h01);
		emu(8'h03);
		emu(8'h00);
		reset_in = 1'b1;
		repeat (2) @(negedge clk_in);
		reset_in = 1'b0;
		chk("switch reset", 16'h0004, {8'h00, switch_control_out});
		chk("threshold reset", 16'hffff, ration_current_limit_out);
		cfgchk(56'h4600_2a04_0306_00);
		rchk(8'h22, 8'h10);
		$display("test second reset done");
		complete_run();
	end
endmodule // charger_port_register_bank_test
